// ===== inc/ssp_pkg.sv
// Operation
// (RULE1) Four wires, full duplex serial link
// (RULE2) Three selectable frame formats
// (RULE3) Frame width 4 to 16 bits
// (RULE4) Serialise transmit, deserialise receive words
// (RULE5) Separate eight-word 16-bit FIFOs
// (RULE6) Master drives clock, slave follows
// (RULE7) Slave can disable its data output
// (RULE8) Prescaler then divider make serial clock
// (RULE9) Peripheral limits usable bit rate
// (RULE10) Internal loopback test mode
// (RULE11) Right-justified data, upper bits zero
// (RULE12) Master starts only with queued word
`default_nettype none
package ssp_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] CTRL0_OFS  = 12'h000;
  localparam logic [11:0] CTRL1_OFS  = 12'h004;
  localparam logic [11:0] DATA_OFS   = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00C;
  localparam logic [11:0] PRESC_OFS  = 12'h010;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int DSS_LSB = 0;
  localparam int FRF_LSB = 4;
  localparam int SPO_BIT = 6;
  localparam int SPH_BIT = 7;
  localparam int SCR_LSB = 8;
  localparam int LBM_BIT = 0;
  localparam int SSE_BIT = 1;
  localparam int MS_BIT  = 2;
  localparam int SOD_BIT = 3;
  localparam logic [31:0] CTRL0_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
  localparam logic [7:0]  PRESC_RST = 8'h02;
  localparam logic [3:0]  DSS_MIN   = 4'h3;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W     = 16;

  typedef enum logic [1:0] {SSP_FMT_SPI, SSP_FMT_SYNC, SSP_FMT_WIRE, SSP_FMT_RSV} ssp_fmt_type;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic frm_o;
    logic frm_oe;
    logic tx_o;
    logic tx_oe;
  } ssp_pins_type;
endpackage
`default_nettype wire

// ===== rtl/ssp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  input  wire logic         rd,
  output logic      [W-1:0] rdata,
  output logic              full,
  output logic              empty,
  output logic              half
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("ssp_fifo depth must be a power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  logic [AW:0]  used;
  assign used  = wp - rp;
  assign full  = used[AW];
  assign empty = (wp == rp);
  assign half  = (used >= (AW+1)'(DEPTH/2));
  assign rdata = mem[rp[AW-1:0]];
  always_ff @(posedge clk)
  begin
    if (wr && !full)
      mem[wp[AW-1:0]] <= wdata;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp <= '0;
      rp <= '0;
    end
    else if (clr)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (wr && !full)
        wp <= wp + 1'b1;
      if (rd && !empty)
        rp <= rp + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ssp_top.sv
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ssp_top #(
  parameter int DEPTH = ssp_pkg::FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sclk_i,
  input  wire logic              frm_i,
  input  wire logic              rx_i,
  output ssp_pkg::ssp_pins_type  pins
);
  initial
  begin
    if (DEPTH < 2)
      $error("ssp_top depth too small");
  end
  // ****************************************
  // Register file
  // ****************************************
  logic [31:0] ctrl0;
  logic [31:0] ctrl1;
  logic [7:0]  presc;
  logic        wr_acc;
  logic        rd_acc;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  logic [3:0]  dss;
  logic [1:0]  frf;
  logic        spo;
  logic        sph;
  logic [7:0]  scr;
  logic        lbm;
  logic        sse;
  logic        slave;
  logic        sod;
  assign dss   = ctrl0[ssp_pkg::DSS_LSB+:4];
  assign frf   = ctrl0[ssp_pkg::FRF_LSB+:2];
  assign spo   = ctrl0[ssp_pkg::SPO_BIT];
  assign sph   = ctrl0[ssp_pkg::SPH_BIT];
  assign scr   = ctrl0[ssp_pkg::SCR_LSB+:8];
  assign lbm   = ctrl1[ssp_pkg::LBM_BIT];
  assign sse   = ctrl1[ssp_pkg::SSE_BIT];
  assign slave = ctrl1[ssp_pkg::MS_BIT];
  assign sod   = ctrl1[ssp_pkg::SOD_BIT];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl0 <= ssp_pkg::CTRL0_RST;
      ctrl1 <= ssp_pkg::CTRL1_RST;
      presc <= ssp_pkg::PRESC_RST;
    end
    else if (wr_acc)
    begin
      if (paddr == ssp_pkg::CTRL0_OFS)
        ctrl0 <= {16'h0000, pwdata[15:0]};
      if (paddr == ssp_pkg::CTRL1_OFS)
        ctrl1 <= {28'h0000000, pwdata[3:0]};
      if (paddr == ssp_pkg::PRESC_OFS)
        presc <= {pwdata[7:1], 1'b0}; // Bit 0 is dropped so the prescale is always even
    end
  end

  // ****************************************
  // FIFOs
  // ****************************************
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic        tx_full;
  logic        tx_empty;
  logic        rx_full;
  logic        rx_empty;
  logic        tx_pop;
  logic        rx_push;
  logic [15:0] rx_word;
  logic        busy;
  logic [15:0] mask;
  assign mask = 16'hFFFF >> (4'hF - dss);

  ssp_fifo #(.W(ssp_pkg::WORD_W), .DEPTH(DEPTH)) u_txf ( // [RULE5]
    .clk   (clk),
    .rst   (rst),
    .clr   (1'b0),
    .wr    (wr_acc && paddr == ssp_pkg::DATA_OFS),
    .wdata (pwdata[15:0] & mask), // [RULE11]
    .rd    (tx_pop),
    .rdata (tx_q),
    .full  (tx_full),
    .empty (tx_empty),
    .half  ()
  );
  ssp_fifo #(.W(ssp_pkg::WORD_W), .DEPTH(DEPTH)) u_rxf ( // [RULE5]
    .clk   (clk),
    .rst   (rst),
    .clr   (1'b0),
    .wr    (rx_push),
    .wdata (rx_word & mask), // [RULE11]
    .rd    (rd_acc && paddr == ssp_pkg::DATA_OFS),
    .rdata (rx_q),
    .full  (rx_full),
    .empty (rx_empty),
    .half  ()
  );

  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      ssp_pkg::CTRL0_OFS:  prdata = ctrl0;
      ssp_pkg::CTRL1_OFS:  prdata = ctrl1;
      ssp_pkg::DATA_OFS:   prdata = {16'h0000, rx_q};
      ssp_pkg::STATUS_OFS: prdata = {27'h0, busy, rx_full, !rx_empty, !tx_full, tx_empty};
      ssp_pkg::PRESC_OFS:  prdata = {24'h000000, presc};
      default:             prdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Bit clock: prescaler then divider
  // ****************************************
  logic [7:0] pre_cnt;
  logic [7:0] div_cnt;
  logic       tick;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_cnt <= 8'h00;
      div_cnt <= 8'h00;
    end
    else if (!busy || slave)
    begin
      pre_cnt <= 8'h00;
      div_cnt <= 8'h00;
    end
    else if (pre_cnt >= presc - 8'h01) // [RULE8]
    begin
      pre_cnt <= 8'h00;
      div_cnt <= (div_cnt == scr) ? 8'h00 : div_cnt + 8'h01;
    end
    else
      pre_cnt <= pre_cnt + 8'h01;
  end
  // One tick per half bit period: presc * (scr+1) clocks
  assign tick = busy && !slave && (pre_cnt >= presc - 8'h01) && (div_cnt == scr); // [RULE8]

  // ****************************************
  // Slave-side edge detection (inputs synchronous)
  // ****************************************
  logic sclk_d;
  logic frm_d;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_d <= 1'b0;
      frm_d  <= 1'b1;
    end
    else
    begin
      sclk_d <= sclk_i;
      frm_d  <= frm_i;
    end
  end

  // ****************************************
  // Shift engine
  // ****************************************
  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  logic [4:0]  half_cnt;
  logic        sclk_m;
  logic        frm_m;
  logic        sdo;
  logic        sdi;
  logic        edge_lead;
  logic        edge_trail;
  logic        s_sample;
  logic        s_shift;
  logic [4:0]  last_half;
  assign last_half = 5'({dss, 1'b1});
  assign sdo = tx_sh[dss];
  // Loopback takes serial out straight back in, pins ignored
  assign sdi = lbm ? sdo : rx_i; // [RULE10]
  // SPI samples on leading edge when phase 0; other formats sample on rising
  assign s_sample = (frf == 2'(ssp_pkg::SSP_FMT_SPI)) ? (sph ? !half_cnt[0] : half_cnt[0]) // [RULE2]
                                                      : half_cnt[0];
  assign edge_lead  = sclk_i && !sclk_d;
  assign edge_trail = !sclk_i && sclk_d;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy     <= 1'b0;
      half_cnt <= 5'h00;
      tx_sh    <= 16'h0000;
      rx_sh    <= 16'h0000;
      sclk_m   <= 1'b0;
      frm_m    <= 1'b1;
      tx_pop   <= 1'b0;
      rx_push  <= 1'b0;
      rx_word  <= 16'h0000;
    end
    else
    begin
      tx_pop  <= 1'b0;
      rx_push <= 1'b0;
      if (!sse || dss < ssp_pkg::DSS_MIN) // [RULE3]
      begin
        busy   <= 1'b0;
        sclk_m <= 1'b0;
        frm_m  <= 1'b1;
      end
      else if (!busy)
      begin
        sclk_m <= 1'b0;
        frm_m  <= (frf == 2'(ssp_pkg::SSP_FMT_SYNC)) ? 1'b0 : 1'b1;
        if (!slave && !tx_empty && !tx_pop) // [RULE12]
        begin
          busy     <= 1'b1;
          half_cnt <= 5'h00;
          tx_sh    <= tx_q; // [RULE4]
          tx_pop   <= 1'b1;
          frm_m    <= (frf == 2'(ssp_pkg::SSP_FMT_SYNC)); // Pulse frame for sync format
        end
        else if (slave && frm_d && !frm_i) // [RULE6]
        begin
          busy     <= 1'b1;
          half_cnt <= 5'h00;
          tx_sh    <= tx_empty ? 16'h0000 : tx_q;
          tx_pop   <= !tx_empty;
        end
      end
      else if (tick || (slave && (edge_lead || edge_trail))) // [RULE6]
      begin
        sclk_m   <= !sclk_m;
        half_cnt <= half_cnt + 5'h01;
        if (frf == 2'(ssp_pkg::SSP_FMT_SYNC))
          frm_m <= 1'b0;
        if (!s_sample)
          rx_sh <= {rx_sh[14:0], sdi}; // [RULE4]
        else if (half_cnt != 5'h00)
          tx_sh <= {tx_sh[14:0], 1'b0}; // [RULE4]
        if (half_cnt == last_half) // [RULE3]
        begin
          busy    <= 1'b0;
          rx_push <= 1'b1; // [RULE4]
          // Phase one samples on the last half too; stale upper bits are cut here
          rx_word <= (s_sample ? rx_sh : {rx_sh[14:0], sdi}) & mask; // [RULE11]
        end
      end
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  always_comb
  begin
    pins.sclk_o  = sclk_m ^ (spo && frf == 2'(ssp_pkg::SSP_FMT_SPI)); // [RULE2]
    pins.sclk_oe = sse && !slave; // [RULE6]
    pins.frm_o   = frm_m ^ (frf == 2'(ssp_pkg::SSP_FMT_SYNC));
    pins.frm_oe  = sse && !slave; // [RULE6]
    pins.tx_o    = sdo; // [RULE1]
    pins.tx_oe   = sse && !(slave && sod) && !lbm; // [RULE7]
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_widths;
    @(posedge clk) disable iff (rst) rx_push |-> (rx_word & ~mask) == 16'h0000;
  endproperty
  a_widths: assert property (p_widths) else $error("received word has upper bits set"); // [RULE11]
  property p_start;
    @(posedge clk) disable iff (rst) $rose(busy) && !slave |-> $past(!tx_empty);
  endproperty
  a_start: assert property (p_start) else $error("master started with empty fifo"); // [RULE12]
  property p_sod;
    @(posedge clk) disable iff (rst) slave && sod |-> !pins.tx_oe;
  endproperty
  a_sod: assert property (p_sod) else $error("slave drove output while disabled"); // [RULE7]
  property p_slave_clk;
    @(posedge clk) disable iff (rst) slave |-> !pins.sclk_oe && !pins.frm_oe;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("slave drove clock"); // [RULE6]
  sequence s_word_end;
    $fell(busy) && sse;
  endsequence
  property p_done;
    @(posedge clk) disable iff (rst) s_word_end |-> rx_push;
  endproperty
  a_done: assert property (p_done) else $error("word end without push"); // [RULE4]
  property p_len;
    @(posedge clk) disable iff (rst) rx_push |-> $past(half_cnt) == last_half;
  endproperty
  a_len: assert property (p_len) else $error("wrong bit count"); // [RULE3]
  property p_loop;
    @(posedge clk) disable iff (rst) lbm |-> sdi == sdo && !pins.tx_oe;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback path broken"); // [RULE10]
  property p_tick;
    @(posedge clk) disable iff (rst) tick |-> busy && !slave;
  endproperty
  a_tick: assert property (p_tick) else $error("bit tick outside master transfer"); // [RULE8]
endmodule
`default_nettype wire

// ===== bench/ssp_peer.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_peer (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire ssp_pkg::ssp_pins_type pins,
  input  wire logic [15:0]           reply,
  input  wire logic [4:0]            width,
  output logic                       rx,
  output logic [15:0]                got
);
  logic       sck_q;
  logic       frm_q;
  logic [3:0] idx;

  // ****************************************
  // Peripheral shift register, MSB first
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sck_q <= 1'b0;
      frm_q <= 1'b1;
      idx   <= 4'h0;
      rx    <= 1'b0;
      got   <= 16'h0;
    end
    else
    begin
      sck_q <= pins.sclk_o;
      frm_q <= pins.frm_o;
      if (pins.frm_o)
        rx <= ~rx; // Deselected line holds no stale bit
      else if (frm_q)
      begin
        rx  <= reply[4'(width - 5'h1)];
        idx <= 4'(width - 5'h2);
        got <= 16'h0;
      end
      else if (sck_q && !pins.sclk_o)
      begin
        rx  <= reply[idx]; // Launch on falling edge
        idx <= idx - 4'h1;
      end
      if (!pins.frm_o && !sck_q && pins.sclk_o)
        got <= {got[14:0], pins.tx_o}; // Capture on rising edge
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [11:0] C0 = ssp_pkg::CTRL0_OFS;
  localparam logic [11:0] C1 = ssp_pkg::CTRL1_OFS;
  localparam logic [11:0] DT = ssp_pkg::DATA_OFS;
  localparam logic [11:0] ST = ssp_pkg::STATUS_OFS;
  localparam logic [11:0] PS = ssp_pkg::PRESC_OFS;
  logic                  clk, rst, psel, penable, pwrite, pready, pslverr;
  logic                  sclk_i, frm_i, rx_i;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, q;
  logic [15:0]           reply, got, d;
  logic [15:0]           e [9];
  logic [4:0]            wid;
  ssp_pkg::ssp_pins_type pins;
  int                    bad_count, checks, n, p, s;

  ssp_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_i(sclk_i), .frm_i(frm_i),
    .rx_i(rx_i), .pins(pins));
  ssp_peer peer_u (.clk(clk), .rst(rst), .pins(pins), .reply(reply), .width(wid), .rx(rx_i), .got(got));

  function automatic logic [15:0] mask(input logic [4:0] w);
    return 16'((17'h1 << w) - 17'h1);
  endfunction

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    checks++;
    if (y !== x)
    begin
      bad_count++;
      $display("FAIL %s exp %h got %h", nm, x, y);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Bus cycles
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      chk("pready", 1, pready);
      wrap_up();
    end
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Status polls are bounded so a stuck engine fails the check instead of hanging
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do
    begin
      apb(0, ST, 0);
      k++;
    end
    while ((q & m) !== v && k < 3000);
    chk("status", v, q & m);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    rst    = 1'b1;
    {psel, penable, pwrite, sclk_i} = 4'h0;
    paddr  = 12'h000;
    pwdata = 32'h0000_0000;
    frm_i  = 1'b1;
    {reply, wid, bad_count, checks} = {16'h0, 5'h10, 64'h0};
    void'($urandom(10646));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(0, C0, 0);
    chk("ctrl0", ssp_pkg::CTRL0_RST, q);
    apb(0, C1, 0);
    chk("ctrl1", ssp_pkg::CTRL1_RST, q);
    apb(0, PS, 0);
    chk("presc", 32'(ssp_pkg::PRESC_RST), q);
    apb(0, ST, 0);
    chk("status", 32'h3, q & 32'h1F);
    apb(0, 12'h020, 0);
    chk("unmapped", 32'h0, q);
    chk("pslverr", 0, pslverr);
    // ****************************************
    // Loopback over every width and format
    // ****************************************
    apb(1, C1, 32'h3);
    for (int i = 0; i < 13; i++)
    begin
      wid = 5'(i + 4);
      d = 16'($urandom);
      s = $urandom_range(3);
      apb(1, C0, 32'(wid - 5'h1) | 32'(i % 3) << 4 | 32'(s) << 6 | 32'($urandom_range(1)) << 8);
      apb(1, DT, {16'hFFFF, d});
      poll(32'h4, 32'h4);
      chk("clk idle", 32'(s % 2 == 1 && i % 3 == 0), 32'(pins.sclk_o));
      apb(0, DT, 0);
      chk("loop", {16'h0, d & mask(wid)}, q);
    end
    // Fill with engine off, one word too many, then drain
    apb(1, C0, 32'hF);
    apb(1, C1, 32'h1);
    for (int i = 0; i < 9; i++)
    begin
      e[i] = 16'($urandom);
      apb(1, DT, {16'h0, e[i]});
    end
    apb(0, ST, 0);
    chk("full", 32'h0, q & 32'h1F);
    apb(1, C1, 32'h3);
    poll(32'h1F, 32'hF);
    for (int i = 0; i < 8; i++)
    begin
      apb(0, DT, 0);
      chk("fifo", {16'h0, e[i]}, q);
    end
    apb(0, ST, 0);
    chk("drained", 32'h3, q & 32'h1F);
    // ****************************************
    // Master against the peripheral
    // ****************************************
    apb(1, C1, 32'h2);
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      if (pins.frm_o !== 1'b1 || pins.sclk_o !== 1'b0)
        n++;
    end
    chk("idle", 0, n);
    chk("master oe", 2'h3, {pins.sclk_oe, pins.frm_oe});
    for (int i = 0; i < 4; i++)
    begin
      wid = 5'($urandom_range(16, 4));
      reply = 16'($urandom);
      d = 16'($urandom);
      p = 2 * $urandom_range(3, 1);
      s = $urandom_range(3);
      apb(1, PS, p); // Rate kept within what the peripheral takes
      apb(1, C0, 32'(wid - 5'h1) | 32'(s) << 8);
      apb(1, DT, {16'h0, d});
      n = 0;
      while (pins.sclk_o !== 1'b1 && n < 400)
      begin
        @(posedge clk);
        n++;
      end
      n = 0;
      while (pins.sclk_o === 1'b1 && n < 400)
      begin
        @(posedge clk);
        n++;
      end
      chk("half period", 32'(p * (s + 1)), 32'(n));
      poll(32'h4, 32'h4);
      apb(0, DT, 0);
      chk("rx word", {16'h0, reply & mask(wid)}, q);
      chk("tx word", {16'h0, d & mask(wid)}, {16'h0, got});
    end
    // Slave with and without output disable
    for (int k = 0; k < 2; k++)
    begin
      apb(1, C1, 32'h6 | 32'(1 - k) << 3);
      chk("slave oe", 0, {pins.sclk_oe, pins.frm_oe});
      apb(1, DT, 32'hA5A5);
      n = 0;
      frm_i <= 1'b0;
      repeat (32)
      begin
        repeat (2) @(posedge clk);
        sclk_i <= ~sclk_i;
        if (pins.tx_oe !== 1'b0)
          n++;
      end
      frm_i <= 1'b1;
      chk("out drive", k, 32'(n > 0));
    end
    wrap_up();
  end
endmodule
`default_nettype wire
